// ### core/pdmc_pkg.sv
// Constants, types and register map of the power-down mode controller
package pdmc_pkg;
  localparam int NMOD = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MHALT = 8'h00;
  localparam logic [7:0] OFS_SCLK = 8'h04;
  localparam logic [7:0] OFS_SYSC = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_EFF = 8'h10;
  localparam int DTC_BIT = 6;
  localparam logic [15:0] MHALT_RST = 16'hFFBF;
  // Modules whose internal state is lost while halted
  localparam logic [15:0] STATE_LOSS_MASK = 16'h0221;
  localparam logic SYSC_RAM_ENABLE_BIT_RST = 1'b1;
  localparam int SCLK_STOP_POS = 0;
  localparam int SCLK_DIR_POS = 1;
  localparam int STAT_RETAIN_POS = 0;
  localparam int STAT_POR_POS = 1;
  localparam int STAT_MODE_POS = 2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LEAD_STATES = 10;
  localparam int RES_RELEASE_GAP_NS = 0;
  localparam int POR_LEAD_NS = 100;
  localparam int POR_LEAD_CYC = (POR_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  localparam int CLKOUT_DIV = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {MODE_RUN, MODE_HWSTBY, MODE_RESET} pdmc_mode_t;

  typedef struct packed {
    logic dir;
    logic stop;
  } pdmc_sclk_t;

  localparam pdmc_sclk_t SCLK_RST = '{dir: 1'b0, stop: 1'b0};

  typedef struct packed {
    logic [1:0] mode;
    logic porOk;
    logic retainOk;
  } pdmc_stat_t;
endpackage

// ### core/pdmc_clkout.sv
// System clock output pin gating by stop bit, direction bit and standby modes
module pdmc_clkout
  import pdmc_pkg::*;
#(
  parameter int DIV = CLKOUT_DIV
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic busCycleEnd,
  input wire pdmc_sclk_t sclk,
  input wire logic swStandby,
  input wire logic hwStandby,
  output logic pinOut,
  output logic pinOe
);
  logic [7:0] divCnt_ff, nxt_divCnt;
  logic phase_ff, nxt_phase;
  logic stop_ff, nxt_stop;
  logic pinOut_ff, nxt_pinOut;
  logic pinOe_ff, nxt_pinOe;

  always_comb begin
    nxt_divCnt = divCnt_ff + 8'h01;
    nxt_phase = phase_ff;
    if (divCnt_ff >= 8'(DIV - 1)) begin
      nxt_divCnt = 8'h00;
      nxt_phase = ~phase_ff;
    end
    // Stop takes effect only at a bus cycle boundary
    nxt_stop = busCycleEnd ? sclk.stop : stop_ff;
    nxt_pinOe = sclk.dir & ~hwStandby;
    if (stop_ff || swStandby) begin
      nxt_pinOut = 1'b1;
    end else begin
      nxt_pinOut = phase_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || hwStandby) begin
      divCnt_ff <= 8'h00;
      phase_ff <= 1'b0;
      stop_ff <= 1'b0;
      pinOut_ff <= 1'b1;
      pinOe_ff <= 1'b0;
    end else begin
      divCnt_ff <= nxt_divCnt;
      phase_ff <= nxt_phase;
      stop_ff <= nxt_stop;
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOe = pinOe_ff;
endmodule

// ### core/pdmc_ctrl.sv
// Power-down mode controller: standby pin sequencing, module halt, clock pin
// How it works
// - Halt bit set halts module at bus cycle end, CPU keeps running.
// - Halt bit cleared resumes module at bus cycle end.
// - Halted modules keep state except serial, CAN and A/D converter.
// - After reset every module halted except the transfer controller.
// - Register accesses to halted modules are blocked.
// - Clock stop bit set stops clock at bus cycle end, pin high.
// - Clock stop bit clear enables clock on the pin.
// - Direction bit clear makes clock pin an input, high impedance always.
// - Pin state table over direction, stop bit and operating mode.
// - I/O ports hold their state during software standby.
// - Standby pin low enters hardware standby from any mode, all reset.
// - Standby rise with reset low enters reset, reset rise starts execution.
module pdmc_ctrl
  import pdmc_pkg::*;
#(
  parameter int NM = NMOD
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic hwStandbyPinN,
  input wire logic swStandbyMode,
  input wire logic busCycleEnd,
  input wire logic dtcActive,
  input wire logic [NM-1:0] periphAccReq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NM-1:0] moduleHalt,
  output logic [NM-1:0] moduleStateClear,
  output logic [NM-1:0] periphAccGrant,
  output logic ioHiZ,
  output logic ioHold,
  output logic chipReset,
  output logic resetExcStart,
  output logic ramEnable,
  output logic clkPinOut,
  output logic clkPinOe
);
  localparam logic [NM-1:0] HALT_RST = MHALT_RST[NM-1:0];
  localparam logic [NM-1:0] LOSS = STATE_LOSS_MASK[NM-1:0];
  localparam logic [CNT_W-1:0] LEAD_CYC = CNT_W'(LEAD_STATES);
  localparam logic [CNT_W-1:0] POR_CYC = CNT_W'(POR_LEAD_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'((LEAD_STATES > POR_LEAD_CYC) ?
                                                LEAD_STATES : POR_LEAD_CYC);

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFS_MHALT) || (a == OFS_SCLK) || (a == OFS_SYSC) ||
           (a == OFS_STAT) || (a == OFS_EFF);
  endfunction

  // Operating mode from the standby and reset pins
  pdmc_mode_t mode_ff, nxt_mode;
  logic resExc_ff, nxt_resExc;
  logic stbyPrev_ff, nxt_stbyPrev;
  logic [CNT_W-1:0] resLowCnt_ff, nxt_resLowCnt;
  logic retainOk_ff, nxt_retainOk;
  logic porOk_ff, nxt_porOk;
  logic ramEnable_ff, nxt_ramEnable;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_resExc = 1'b0;
    nxt_stbyPrev = hwStandbyPinN;
    nxt_retainOk = retainOk_ff;
    nxt_porOk = porOk_ff;
    if (!resetPinN) begin
      nxt_resLowCnt = (resLowCnt_ff == CNT_MAX) ? resLowCnt_ff : resLowCnt_ff + 1'b1;
    end else begin
      nxt_resLowCnt = '0;
    end
    // Lead time check on standby fall, only needed when RAM is kept
    if (stbyPrev_ff && !hwStandbyPinN) begin
      nxt_retainOk = !ramEnable_ff || (resLowCnt_ff >= LEAD_CYC);
    end
    if (!stbyPrev_ff && hwStandbyPinN) begin
      nxt_porOk = !resetPinN && (resLowCnt_ff >= POR_CYC);
    end
    unique case (mode_ff)
      MODE_RUN: begin
        if (!hwStandbyPinN) begin
          nxt_mode = MODE_HWSTBY;
        end else if (!resetPinN) begin
          nxt_mode = MODE_RESET;
        end
      end
      MODE_HWSTBY: begin
        // Leaving standby always passes through the reset state
        if (hwStandbyPinN) begin
          nxt_mode = MODE_RESET;
        end
      end
      MODE_RESET: begin
        if (!hwStandbyPinN) begin
          nxt_mode = MODE_HWSTBY;
        end else if (resetPinN) begin
          nxt_mode = MODE_RUN;
          nxt_resExc = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_ff <= MODE_RESET;
      resExc_ff <= 1'b0;
      stbyPrev_ff <= 1'b1;
      resLowCnt_ff <= '0;
      retainOk_ff <= 1'b0;
      porOk_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      resExc_ff <= nxt_resExc;
      stbyPrev_ff <= nxt_stbyPrev;
      resLowCnt_ff <= nxt_resLowCnt;
      retainOk_ff <= nxt_retainOk;
      porOk_ff <= nxt_porOk;
    end
  end

  // Control registers, cleared whenever the chip is not running, except ioHiZ_ff, which only srst clears
  logic funcReset;
  logic [NM-1:0] halt_ff, nxt_halt;
  pdmc_sclk_t sclk_ff, nxt_sclk;
  logic [NM-1:0] haltEff_ff, nxt_haltEff;
  logic [NM-1:0] loss_ff, nxt_loss;
  logic [NM-1:0] grant_ff, nxt_grant;
  logic ioHiZ_ff, nxt_ioHiZ;
  logic ioHold_ff, nxt_ioHold;

  // AXI4-Lite slave state
  logic awHave_ff, nxt_awHave;
  logic wHave_ff, nxt_wHave;
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic awReady_ff, nxt_awReady;
  logic wReady_ff, nxt_wReady;
  logic arReady_ff, nxt_arReady;
  logic rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;
  logic doWrite;
  logic [31:0] wMerged;
  pdmc_stat_t stat;

  assign funcReset = srst || (mode_ff != MODE_RUN);

  always_comb begin
    nxt_awHave = awHave_ff;
    nxt_wHave = wHave_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    nxt_halt = halt_ff;
    nxt_sclk = sclk_ff;
    nxt_ramEnable = ramEnable_ff;
    stat = '{mode: mode_ff, porOk: porOk_ff, retainOk: retainOk_ff};
    wMerged = '0;
    if (s_axi_awvalid && awReady_ff) begin
      nxt_awHave = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_ff) begin
      nxt_wHave = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    doWrite = awHave_ff && wHave_ff && !bValid_ff;
    if (doWrite) begin
      nxt_awHave = 1'b0;
      nxt_wHave = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = addr_known(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      unique case (awAddr_ff)
        OFS_MHALT: begin
          wMerged = lane_merge(32'(halt_ff), wData_ff, wStrb_ff);
          nxt_halt = wMerged[NM-1:0];
          // Transfer controller cannot be halted mid-transfer
          if (dtcActive && !halt_ff[DTC_BIT]) begin
            nxt_halt[DTC_BIT] = 1'b0;
          end
        end
        OFS_SCLK: begin
          if (wStrb_ff[0]) begin
            nxt_sclk.stop = wData_ff[SCLK_STOP_POS];
            nxt_sclk.dir = wData_ff[SCLK_DIR_POS];
          end
        end
        OFS_SYSC: begin
          if (wStrb_ff[0]) begin
            nxt_ramEnable = wData_ff[0];
          end
        end
        default: begin
          wMerged = '0;
        end
      endcase
    end else if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (s_axi_arvalid && arReady_ff) begin
      nxt_rValid = 1'b1;
      nxt_rResp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_MHALT: nxt_rData = 32'(halt_ff);
        OFS_SCLK: nxt_rData = 32'({sclk_ff.dir, sclk_ff.stop});
        OFS_SYSC: nxt_rData = 32'(ramEnable_ff);
        OFS_STAT: nxt_rData = 32'(stat);
        OFS_EFF: nxt_rData = 32'(haltEff_ff);
        default: nxt_rData = '0;
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
    nxt_awReady = !nxt_awHave && !nxt_bValid;
    nxt_wReady = !nxt_wHave && !nxt_bValid;
    nxt_arReady = !nxt_rValid;
    // Halt and resume only at a bus cycle boundary
    nxt_haltEff = busCycleEnd ? halt_ff : haltEff_ff;
    nxt_loss = haltEff_ff & LOSS;
    nxt_grant = periphAccReq & ~haltEff_ff;
    nxt_ioHiZ = (mode_ff == MODE_HWSTBY);
    nxt_ioHold = swStandbyMode;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= RESP_OKAY;
    end else begin
      awHave_ff <= nxt_awHave;
      wHave_ff <= nxt_wHave;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      awReady_ff <= nxt_awReady;
      wReady_ff <= nxt_wReady;
      arReady_ff <= nxt_arReady;
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
    end
  end

  always_ff @(posedge mclk) begin
    if (funcReset) begin
      halt_ff <= HALT_RST;
      haltEff_ff <= HALT_RST;
      sclk_ff <= SCLK_RST;
      ramEnable_ff <= SYSC_RAM_ENABLE_BIT_RST;
      loss_ff <= HALT_RST & LOSS;
      grant_ff <= '0;
      ioHold_ff <= 1'b0;
    end else begin
      halt_ff <= nxt_halt;
      haltEff_ff <= nxt_haltEff;
      sclk_ff <= nxt_sclk;
      ramEnable_ff <= nxt_ramEnable;
      loss_ff <= nxt_loss;
      grant_ff <= nxt_grant;
      ioHold_ff <= nxt_ioHold;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ioHiZ_ff <= 1'b0;
    end else begin
      ioHiZ_ff <= nxt_ioHiZ;
    end
  end

  logic chipReset_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      chipReset_ff <= 1'b1;
    end else begin
      chipReset_ff <= (nxt_mode != MODE_RUN);
    end
  end

  pdmc_clkout #(
    .DIV(CLKOUT_DIV)
  ) u_clkout (
    .mclk(mclk),
    .srst(srst),
    .busCycleEnd(busCycleEnd),
    .sclk(sclk_ff),
    .swStandby(swStandbyMode),
    .hwStandby(mode_ff == MODE_HWSTBY),
    .pinOut(clkPinOut),
    .pinOe(clkPinOe)
  );

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign moduleHalt = haltEff_ff;
  assign moduleStateClear = loss_ff;
  assign periphAccGrant = grant_ff;
  assign ioHiZ = ioHiZ_ff;
  assign ioHold = ioHold_ff;
  assign chipReset = chipReset_ff;
  assign resetExcStart = resExc_ff;
  assign ramEnable = ramEnable_ff;
endmodule

// ### sim/pdmc_board.sv
// Board supervisor model driving the reset and standby pins
module pdmc_board
  import pdmc_pkg::*;
(
  input wire logic mclk,
  output logic resetPinN,
  output logic hwStandbyPinN
);
  initial begin
    resetPinN = 1'b1;
    hwStandbyPinN = 1'b1;
  end

  // A lead of zero skips the reset pulse: only legal when RAM may be lost
  task automatic enter_hw_standby_pin_n(input int lead);
    @(posedge mclk);
    if (lead > 0) begin
      resetPinN <= 1'b0;
      repeat (lead) @(posedge mclk);
    end
    hwStandbyPinN <= 1'b0;
    @(posedge mclk);
    resetPinN <= 1'b1;
  endtask

  task automatic leave_hw_standby_pin_n(input int lead);
    @(posedge mclk);
    resetPinN <= 1'b0;
    repeat (lead) @(posedge mclk);
    hwStandbyPinN <= 1'b1;
    @(posedge mclk);
    resetPinN <= 1'b1;
  endtask
endmodule

// ### sim/pdmc_properties.sv
// Concurrent checks on the power-down controller ports
module pdmc_properties
  import pdmc_pkg::*;
#(
  parameter int NM = NMOD
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic hwStandbyPinN,
  input wire logic swStandbyMode,
  input wire logic busCycleEnd,
  input wire logic [NM-1:0] periphAccReq,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [NM-1:0] moduleHalt,
  input wire logic [NM-1:0] moduleStateClear,
  input wire logic [NM-1:0] periphAccGrant,
  input wire logic ioHiZ,
  input wire logic ioHold,
  input wire logic chipReset,
  input wire logic resetExcStart,
  input wire logic clkPinOut,
  input wire logic clkPinOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  halt_at_end_a: assert property ($changed(moduleHalt) |-> $past(busCycleEnd)
    || $past(busCycleEnd, 2) || chipReset || $past(chipReset)) else $error("halt moved early");
  // Grants are cleared while the chip is held in reset
  grant_gate_a: assert property (periphAccGrant == ($past(chipReset) ? {NM{1'b0}} :
    ($past(periphAccReq) & ~$past(moduleHalt)))) else $error("grant ignores halt");
  state_loss_a: assert property (!$past(srst) && $stable(moduleHalt) |->
    moduleStateClear == (moduleHalt & STATE_LOSS_MASK)) else $error("state clear wrong");
  port_hold_a: assert property (ioHold == (!$past(chipReset) && $past(swStandbyMode)))
    else $error("hold lost");
  hiz_entry_a: assert property (!hwStandbyPinN [*3] |-> ioHiZ && chipReset)
    else $error("standby not entered");
  hiz_pin_a: assert property (ioHiZ && $past(ioHiZ) |-> !clkPinOe)
    else $error("clock pin driven in standby");
  sw_high_a: assert property ($past(swStandbyMode) && $past(swStandbyMode, 2) && clkPinOe
    |-> clkPinOut) else $error("clock pin not high");
  exc_pulse_a: assert property (resetExcStart |=> !resetExcStart) else $error("long pulse");
  reset_pin_a: assert property (!resetPinN [*3] |-> chipReset) else $error("reset ignored");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");

  cover property (resetExcStart);
  cover property (ioHiZ);
  cover property ($rose(clkPinOut) && clkPinOe);
endmodule

bind pdmc_ctrl pdmc_properties #(.NM(NM)) prop_u (.mclk, .srst, .resetPinN, .hwStandbyPinN,
  .swStandbyMode, .busCycleEnd, .periphAccReq, .s_axi_arready, .s_axi_rvalid, .moduleHalt,
  .moduleStateClear, .periphAccGrant, .ioHiZ, .ioHold, .chipReset, .resetExcStart,
  .clkPinOut, .clkPinOe);

// ### sim/tb_top.sv
// Self-checking bench for the power-down mode controller
module tb_top
  import pdmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic swStandbyMode = 1'b0, busCycleEnd = 1'b0, dtcActive = 1'b0;
  logic [15:0] periphAccReq = 16'h0000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdv;
  logic [1:0] rsp;
  logic [15:0] moduleHalt, moduleStateClear, periphAccGrant;
  logic resetPinN, hwStandbyPinN, ioHiZ, ioHold, chipReset, resetExcStart;
  logic ramEnable, clkPinOut, clkPinOe;
  int errorCnt = 0, totalChecks = 0;

  always #4 mclk = ~mclk;

  pdmc_board board_u (.mclk, .resetPinN, .hwStandbyPinN);
  pdmc_ctrl #(.NM(16)) dut_u (.mclk, .srst, .resetPinN, .hwStandbyPinN, .swStandbyMode,
    .busCycleEnd, .dtcActive, .periphAccReq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .moduleHalt, .moduleStateClear, .periphAccGrant, .ioHiZ,
    .ioHold, .chipReset, .resetExcStart, .ramEnable, .clkPinOut, .clkPinOe);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Halt updates wait for the end of a bus cycle
  task automatic pulse();
    @(posedge mclk);
    busCycleEnd <= 1'b1;
    @(posedge mclk);
    busCycleEnd <= 1'b0;
    cyc(2);
  endtask

  task automatic t_reset();
    chk(moduleHalt, MHALT_RST);
    rd(OFS_MHALT);
    chk(rdv, MHALT_RST);
    rd(OFS_SYSC);
    chk(rdv, SYSC_RAM_ENABLE_BIT_RST);
    rd(8'h14);
    chk(rsp, RESP_SLVERR);
    chk(rdv, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_halt();
    // Bench raises dtcActive for the second write, so its transfer controller halt is refused
    wr(OFS_MHALT, 32'h0223);
    cyc(2);
    chk(moduleHalt, MHALT_RST);
    pulse();
    chk(moduleHalt, 16'h0223);
    chk(moduleStateClear, 16'h0221);
    rd(OFS_EFF);
    chk(rdv, 32'h0223);
    periphAccReq <= 16'hFFFF;
    cyc(3);
    chk(periphAccGrant, 16'hFDDC);
    periphAccReq <= 16'h0000;
    dtcActive <= 1'b1;
    wr(OFS_MHALT, 32'h0263);
    rd(OFS_MHALT);
    chk(rdv, 32'h0223);
    dtcActive <= 1'b0;
    $display("halt test done");
  endtask

  task automatic t_clk();
    logic a;
    wr(OFS_SCLK, 32'h2);
    cyc(3);
    chk(clkPinOe, 1'b1);
    a = clkPinOut;
    cyc(1);
    chk(a ^ clkPinOut, 1'b1);
    swStandbyMode <= 1'b1;
    cyc(3);
    chk(ioHold, 1'b1);
    chk(clkPinOut, 1'b1);
    swStandbyMode <= 1'b0;
    wr(OFS_SCLK, 32'h3);
    pulse();
    chk(clkPinOut, 1'b1);
    cyc(1);
    chk(clkPinOut, 1'b1);
    wr(OFS_SCLK, 32'h0);
    cyc(3);
    chk(clkPinOe, 1'b0);
    $display("clock pin test done");
  endtask

  task automatic t_hw_standby_pin_n(input int lead, input logic ram);
    int seen;
    seen = 0;
    wr(OFS_SCLK, 32'h2);
    wr(OFS_SYSC, {31'h0, ram});
    board_u.enter_hw_standby_pin_n(lead);
    cyc(3);
    chk(ioHiZ, 1'b1);
    chk(chipReset, 1'b1);
    chk(clkPinOe, 1'b0);
    board_u.leave_hw_standby_pin_n(POR_LEAD_CYC + 2);
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      if (resetExcStart === 1'b1) seen++;
    end
    chk(seen, 1);
    chk(chipReset, 1'b0);
    chk(ioHiZ, 1'b0);
    chk(ramEnable, SYSC_RAM_ENABLE_BIT_RST);
    chk(moduleHalt, MHALT_RST);
    // Mode run, power-on lead met; RAM kept only with the lead or with RAM disabled
    rd(OFS_STAT);
    chk(rdv, {30'h0, 1'b1, (lead >= LEAD_STATES) || !ram});
    $display("standby test done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    cyc(4);
    t_reset();
    t_halt();
    t_clk();
    t_hw_standby_pin_n(LEAD_STATES + 2, 1'b1);
    t_hw_standby_pin_n(0, 1'b0);
    t_hw_standby_pin_n(0, 1'b1);
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    errorCnt++;
    finish_test();
  end
endmodule
